/* File: shared/cphl_pkg.sv */
// Package for the packet link host controller: framing constants, types and timing.
package cphl_pkg;

  localparam int          CLK_HZ            = 250_000_000;
  localparam int          ACK_TIMEOUT_MS    = 250;
  localparam int          ACK_TIMEOUT_CYC   = (CLK_HZ / 1000) * ACK_TIMEOUT_MS;
  localparam logic [3:0]  MAX_RETRIES       = 4'h3;
  localparam logic [7:0]  MAX_PAYLOAD       = 8'h16;
  localparam logic [15:0] CRC_POLY          = 16'h8408;
  localparam logic [15:0] CRC_INIT          = 16'hFFFF;
  localparam logic [1:0]  CLASS_CMD         = 2'h0;
  localparam logic [1:0]  CLASS_RESP        = 2'h1;
  localparam logic [1:0]  CLASS_REPORT      = 2'h2;
  localparam logic [1:0]  CLASS_ERROR       = 2'h3;
  localparam logic [7:0]  TYPE_KEY_REPORT   = 8'h80;
  localparam logic [7:0]  TYPE_FAN_REPORT   = 8'h81;
  localparam logic [7:0]  TYPE_TEMP_REPORT  = 8'h82;
  localparam logic [7:0]  FAN_STOP_LIMIT    = 8'h03;
  localparam logic [7:0]  FAN_SLOW_LIMIT    = 8'h04;
  localparam logic [7:0]  FAN_INVALID       = 8'hFF;
  localparam logic [7:0]  KEY_LAST_CODE     = 8'h0C;
  localparam int          FIFO_DEPTH        = 4;
  localparam int          BYTE_W            = 8;

  // Type byte layout
  typedef struct packed {
    logic [1:0] pclass;
    logic [5:0] code;
  } cphl_type_t;

  // Received packet summary handed to the user
  typedef struct packed {
    cphl_type_t ptype;
    logic [7:0] len;
    logic [7:0] pay0;
    logic [7:0] pay1;
    logic [7:0] pay2;
  } cphl_rx_pkt_t;

  // Fan report classification
  typedef enum logic [1:0] {
    FAN_RUN,
    FAN_SLOW,
    FAN_STOPPED,
    FAN_BAD
  } cphl_fan_t;

  // Byte stream beat
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } cphl_byte_t;

endpackage : cphl_pkg

/* File: src/cphl_fifo.sv */
// Small valid/ready FIFO buffering incoming link bytes.
`timescale 1ns/1ps
`default_nettype none
module cphl_fifo
  import cphl_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rstn_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
    logic [WIDTH-1:0]            rdata;
    logic                        rvalid;
    logic                        rdy;
  } cphl_fifo_st_t;

  cphl_fifo_st_t st_reg;
  cphl_fifo_st_t st_next;
  logic          push;
  logic          pop;
  logic          load;

  // Output register refills whenever empty or being taken
  always_comb begin
    st_next = st_reg;
    load    = (!st_reg.rvalid || out_ready_in) && (st_reg.count != '0);
    push    = in_valid_in && (st_reg.count != (AW+1)'(DEPTH));
    pop     = load;
    if (push) begin
      st_next.mem[st_reg.wptr] = in_data_in;
      st_next.wptr             = st_reg.wptr + 1'b1;
    end
    if (st_reg.rvalid && out_ready_in) begin
      st_next.rvalid = 1'b0;
    end
    if (load) begin
      st_next.rdata  = st_reg.mem[st_reg.rptr];
      st_next.rvalid = 1'b1;
      st_next.rptr   = st_reg.rptr + 1'b1;
    end
    st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
    // Room flag kept in a flop so the ready port is registered
    st_next.rdy   = (st_next.count != (AW+1)'(DEPTH));
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      st_reg     <= '0;
      st_reg.rdy <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign in_ready_out  = st_reg.rdy;
  assign out_valid_out = st_reg.rvalid;
  assign out_data_out  = st_reg.rdata;

endmodule : cphl_fifo
`default_nettype wire

/* File: src/cphl_host.sv */
// Host side packet framer: sends commands, retries on timeout, parses and checks incoming packets.
//
// Contract
// R1 - Packets are type byte, length byte, payload, then CRC, both directions.
// R2 - Type byte top two bits are class, low six bits the code.
// R3 - Class 00 command, 01 response, 10 report, 11 error response.
// R4 - Length field is 0 to 22; longer payloads never occur.
// R5 - Length equals the number of payload bytes before the CRC.
// R6 - 16-bit CRC covers every byte except the CRC itself.
// R7 - CRC goes low byte first, right after the last payload byte.
// R8 - Host sends a new command only after the previous one was acknowledged.
// R9 - Device answers each command within 250 ms.
// R10 - Host resends after 250 ms silence and flags an error after several retries.
// R11 - Acknowledge code bits equal the command's low six bits.
// R12 - Host buffers incoming packets and drains them faster than they arrive.
// R13 - Host classifies every incoming packet by its type, not by arrival order.
// R14 - Device sends enabled reports on its own whenever new data exists.
// R15 - Key events come as type 0x80 reports with one payload byte.
// R16 - Key codes 1-6 are presses, 7-12 releases of the six keys.
// R17 - Key press and release reporting is enabled per key by the device.
// R18 - Fan reports of type 0x81 come every half second per selected fan.
// R19 - Fan report byte 1 tach cycles, bytes 2-3 ticks; below 3 stop, 4 slow, FF invalid.
// R20 - Temperature reports of type 0x82 come every second per selected sensor.
// R21 - Link runs at 115200 baud, 8 data bits, no parity, one stop bit.
// R22 - Bad CRC or oversize length packets are discarded and the parser resynchronises.
`timescale 1ns/1ps
`default_nettype none
module cphl_host
  import cphl_pkg::*;
#(
  parameter int ACK_CYCLES = ACK_TIMEOUT_CYC
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rstn_in,
  // Command request from user
  input  wire logic         cmd_valid_in,
  input  wire logic [5:0]   cmd_code_in,
  input  wire logic [7:0]   cmd_len_in,
  input  wire logic [175:0] cmd_payload_in,
  output logic              cmd_ready_out,
  output logic              cmd_done_out,
  output logic              cmd_nak_out,
  output logic              cmd_fail_out,
  // Byte stream toward the serial port
  output logic              tx_valid_out,
  output logic [7:0]        tx_data_out,
  input  wire logic         tx_ready_in,
  // Byte stream from the serial port
  input  wire logic         rx_valid_in,
  input  wire logic [7:0]   rx_data_in,
  output logic              rx_ready_out,
  // Parsed incoming packets
  output logic              pkt_valid_out,
  output cphl_rx_pkt_t      pkt_out,
  output logic              key_valid_out,
  output logic [7:0]        key_code_out,
  output logic              fan_valid_out,
  output cphl_fan_t         fan_state_out,
  output logic              temp_valid_out,
  output logic              crc_err_out
);

  typedef enum logic [2:0] {TX_IDLE, TX_TYPE, TX_LEN, TX_PAY, TX_CRCL, TX_CRCH, TX_WAIT} tx_st_t;
  typedef enum logic [2:0] {RX_TYPE, RX_LEN, RX_PAY, RX_CRCL, RX_CRCH} rx_st_t;

  typedef struct packed {
    tx_st_t       tx_st;
    logic [5:0]   code;
    logic [7:0]   len;
    logic [175:0] pay;
    logic [4:0]   tidx;
    logic [15:0]  tcrc;
    logic [31:0]  timer;
    logic [3:0]   tries;
    logic         txv;
    logic [7:0]   txd;
    logic         done;
    logic         nak;
    logic         fail;
    rx_st_t       rx_st;
    cphl_rx_pkt_t rp;
    logic [4:0]   ridx;
    logic [15:0]  rcrc;
    logic [7:0]   crcl;
    logic         pv;
    cphl_rx_pkt_t po;
    logic         kv;
    logic         fv;
    cphl_fan_t    fs;
    logic         tv;
    logic         ce;
    logic         rdy;
  } host_st_t;

  host_st_t   st_reg;
  host_st_t   st_next;
  logic       fb_valid;
  logic [7:0] fb_data;
  logic       fb_ready;
  logic       tx_fire;
  logic       ack_match;

  // CRC-16 update, one byte, reflected polynomial
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  // Incoming bytes are buffered so reports never stall the link
  cphl_fifo #(
    .WIDTH (BYTE_W), // R21
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .sys_clk_in    (sys_clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (rx_valid_in),
    .in_ready_out  (rx_ready_out),
    .in_data_in    (rx_data_in),
    .out_valid_out (fb_valid),
    .out_ready_in  (fb_ready),
    .out_data_out  (fb_data)
  );

  assign fb_ready = 1'b1; // R12
  assign tx_fire  = st_reg.txv && tx_ready_in;

  // Next state of transmitter and receiver
  always_comb begin
    st_next    = st_reg;
    st_next.done = 1'b0;
    st_next.nak  = 1'b0;
    st_next.fail = 1'b0;
    st_next.pv   = 1'b0;
    st_next.kv   = 1'b0;
    st_next.fv   = 1'b0;
    st_next.tv   = 1'b0;
    st_next.ce   = 1'b0;
    ack_match    = 1'b0;

    // Transmit framer
    case (st_reg.tx_st)
      TX_IDLE: begin
        if (cmd_valid_in) begin // R8
          st_next.code  = cmd_code_in;
          st_next.len   = (cmd_len_in > MAX_PAYLOAD) ? MAX_PAYLOAD : cmd_len_in; // R4
          st_next.pay   = cmd_payload_in;
          st_next.tries = '0;
          st_next.tx_st = TX_TYPE;
        end
      end
      TX_TYPE: begin
        if (!st_reg.txv) begin
          st_next.txv  = 1'b1;
          st_next.txd  = {CLASS_CMD, st_reg.code}; // R1 R2 R3
          st_next.tcrc = crc_step(CRC_INIT, {CLASS_CMD, st_reg.code}); // R6
        end else if (tx_fire) begin
          st_next.txd   = st_reg.len;
          st_next.tcrc  = crc_step(st_reg.tcrc, st_reg.len);
          st_next.tx_st = TX_LEN;
        end
      end
      TX_LEN: begin
        if (tx_fire) begin
          st_next.tidx = '0;
          if (st_reg.len == 8'h00) begin
            st_next.txd   = st_reg.tcrc[7:0]; // R7
            st_next.tx_st = TX_CRCL;
          end else begin
            st_next.txd   = st_reg.pay[7:0]; // R5
            st_next.tcrc  = crc_step(st_reg.tcrc, st_reg.pay[7:0]);
            st_next.tx_st = TX_PAY;
          end
        end
      end
      TX_PAY: begin
        if (tx_fire) begin
          if ({3'h0, st_reg.tidx} + 8'h01 == st_reg.len) begin
            st_next.txd   = st_reg.tcrc[7:0]; // R7
            st_next.tx_st = TX_CRCL;
          end else begin
            st_next.tidx = st_reg.tidx + 5'h01;
            st_next.txd  = st_reg.pay[8*(st_reg.tidx+5'h01) +: 8];
            st_next.tcrc = crc_step(st_reg.tcrc, st_reg.pay[8*(st_reg.tidx+5'h01) +: 8]);
          end
        end
      end
      TX_CRCL: begin
        if (tx_fire) begin
          st_next.txd   = st_reg.tcrc[15:8];
          st_next.tx_st = TX_CRCH;
        end
      end
      TX_CRCH: begin
        if (tx_fire) begin
          st_next.txv   = 1'b0;
          st_next.timer = '0;
          st_next.tx_st = TX_WAIT;
        end
      end
      TX_WAIT: begin
        st_next.timer = st_reg.timer + 32'h1;
        if (st_reg.timer >= 32'(ACK_CYCLES - 1)) begin // R9 R10
          if (st_reg.tries >= MAX_RETRIES) begin
            st_next.fail  = 1'b1; // R10
            st_next.tx_st = TX_IDLE;
          end else begin
            st_next.tries = st_reg.tries + 4'h1;
            st_next.tx_st = TX_TYPE;
          end
        end
      end
      default: st_next.tx_st = TX_IDLE;
    endcase

    // Receive parser, always draining the buffer
    if (fb_valid) begin
      case (st_reg.rx_st)
        RX_TYPE: begin
          st_next.rp       = '0;
          st_next.rp.ptype = fb_data; // R13
          st_next.rcrc     = crc_step(CRC_INIT, fb_data);
          st_next.rx_st    = RX_LEN;
        end
        RX_LEN: begin
          st_next.rp.len = fb_data;
          st_next.rcrc   = crc_step(st_reg.rcrc, fb_data);
          st_next.ridx   = '0;
          if (fb_data > MAX_PAYLOAD) begin
            st_next.ce    = 1'b1; // R22
            st_next.rx_st = RX_TYPE;
          end else begin
            st_next.rx_st = (fb_data == 8'h00) ? RX_CRCL : RX_PAY;
          end
        end
        RX_PAY: begin
          st_next.rcrc = crc_step(st_reg.rcrc, fb_data);
          if (st_reg.ridx == 5'h00) st_next.rp.pay0 = fb_data;
          if (st_reg.ridx == 5'h01) st_next.rp.pay1 = fb_data;
          if (st_reg.ridx == 5'h02) st_next.rp.pay2 = fb_data;
          st_next.ridx = st_reg.ridx + 5'h01;
          if ({3'h0, st_reg.ridx} + 8'h01 == st_reg.rp.len) begin
            st_next.rx_st = RX_CRCL; // R5
          end
        end
        RX_CRCL: begin
          st_next.crcl  = fb_data; // R7
          st_next.rx_st = RX_CRCH;
        end
        RX_CRCH: begin
          st_next.rx_st = RX_TYPE;
          if ({fb_data, st_reg.crcl} != st_reg.rcrc) begin
            st_next.ce = 1'b1; // R22
          end else begin
            st_next.pv = 1'b1;
            st_next.po = st_reg.rp;
            // Classify by type field
            case (st_reg.rp.ptype.pclass) // R13
              CLASS_RESP, CLASS_ERROR: begin
                ack_match = (st_reg.tx_st == TX_WAIT) && (st_reg.rp.ptype.code == st_reg.code); // R11
                if (ack_match) begin
                  st_next.done  = (st_reg.rp.ptype.pclass == CLASS_RESP);
                  st_next.nak   = (st_reg.rp.ptype.pclass == CLASS_ERROR);
                  st_next.tx_st = TX_IDLE;
                end
              end
              CLASS_REPORT: begin
                if (st_reg.rp.ptype == TYPE_KEY_REPORT) begin
                  st_next.kv = (st_reg.rp.pay0 != 8'h00) && (st_reg.rp.pay0 <= KEY_LAST_CODE); // R15 R16
                end
                if (st_reg.rp.ptype == TYPE_FAN_REPORT) begin
                  st_next.fv = 1'b1; // R18
                  if (st_reg.rp.pay1 == FAN_INVALID) st_next.fs = FAN_BAD; // R19
                  else if (st_reg.rp.pay1 < FAN_STOP_LIMIT) st_next.fs = FAN_STOPPED;
                  else if (st_reg.rp.pay1 < FAN_SLOW_LIMIT) st_next.fs = FAN_SLOW;
                  else st_next.fs = FAN_RUN;
                end
                st_next.tv = (st_reg.rp.ptype == TYPE_TEMP_REPORT); // R20
              end
              default: st_next.pv = 1'b1;
            endcase
          end
        end
        default: st_next.rx_st = RX_TYPE;
      endcase
    end
    // Ready is registered from the next transmit state
    st_next.rdy = (st_next.tx_st == TX_IDLE); // R8
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      st_reg     <= '0;
      st_reg.rdy <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state flops
  assign cmd_ready_out  = st_reg.rdy;
  assign cmd_done_out   = st_reg.done;
  assign cmd_nak_out    = st_reg.nak;
  assign cmd_fail_out   = st_reg.fail;
  assign tx_valid_out   = st_reg.txv;
  assign tx_data_out    = st_reg.txd;
  assign pkt_valid_out  = st_reg.pv;
  assign pkt_out        = st_reg.po;
  assign key_valid_out  = st_reg.kv;
  assign key_code_out   = st_reg.po.pay0;
  assign fan_valid_out  = st_reg.fv;
  assign fan_state_out  = st_reg.fs;
  assign temp_valid_out = st_reg.tv;
  assign crc_err_out    = st_reg.ce;

endmodule : cphl_host
`default_nettype wire

/* File: tb/cphl_dev_model.sv */
// Display module model: answers commands and sends reports.
`timescale 1ns/1ps
`default_nettype none
module cphl_dev_model
  import cphl_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            tx_ready_out,
  output logic            rx_valid_out,
  output logic      [7:0] rx_data_out,
  input  wire logic       rx_ready_in,
  input  wire logic [1:0] mode_in,
  input  wire logic       slow_in
);
  logic [7:0]  rb [0:27];
  logic [15:0] crc;
  logic [15:0] key_en = 16'hFFFF;
  int          cnt = 0;
  int          pkts = 0;
  int          bad_cnt = 0;
  int          k;
  event        got;

  // One CRC step over a byte
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction : crc_step

  // Send a packet, each byte held until taken; bad flips the CRC
  task automatic send_pkt(input logic [7:0] t, input logic [7:0] n, input logic [175:0] p, input logic bad);
    logic [7:0]  b [0:27];
    logic [15:0] c;
    int          m;
    if (t == TYPE_KEY_REPORT && !key_en[p[3:0]]) return;
    b[0] = t;
    b[1] = n;
    c = crc_step(crc_step(CRC_INIT, t), n);
    for (int i = 0; i < 22; i++) begin
      b[i + 2] = p[8*i +: 8];
      if (i < n) c = crc_step(c, b[i + 2]);
    end
    c = bad ? ~c : c;
    b[n + 2] = c[7:0];
    b[n + 3] = c[15:8];
    m = (n > MAX_PAYLOAD) ? 2 : n + 4;
    @(posedge sys_clk_in);
    for (int i = 0; i < m; i++) begin
      rx_valid_out <= 1'b1;
      rx_data_out  <= b[i];
      do @(posedge sys_clk_in); while (!rx_ready_in);
    end
    rx_valid_out <= 1'b0;
    rx_data_out  <= ~b[m - 1];
  endtask : send_pkt

  // Idle levels at start
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out  = 8'h00;
    tx_ready_out = 1'b0;
  end

  // Collect command bytes; ready toggles when slow
  always @(posedge sys_clk_in) begin
    tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
    if (!rstn_in) begin
      cnt <= 0;
    end else if (tx_valid_in && tx_ready_out) begin
      rb[cnt] <= tx_data_in;
      cnt     <= cnt + 1;
      if (cnt >= 2 && cnt + 1 == rb[1] + 4) begin
        cnt  <= 0;
        pkts <= pkts + 1;
        -> got;
      end
    end
  end

  // Check the command CRC, then answer as the mode says
  initial forever begin
    @got;
    #1;
    crc = CRC_INIT;
    for (k = 0; k < rb[1] + 2; k++) crc = crc_step(crc, rb[k]);
    if ({rb[rb[1] + 3], rb[rb[1] + 2]} !== crc) bad_cnt++;
    repeat (slow_in ? 40 : 2) @(posedge sys_clk_in);
    if (mode_in == 2'h3) send_pkt({CLASS_RESP, rb[0][5:0] + 6'h01}, 8'h00, '0, 1'b0);
    if (mode_in != 2'h2) send_pkt({(mode_in == 2'h1) ? CLASS_ERROR : CLASS_RESP, rb[0][5:0]}, 8'h00, '0, 1'b0);
  end
endmodule : cphl_dev_model
`default_nettype wire

/* File: tb/cphl_host_asserts.sv */
// Concurrent checks on the host link controller ports.
`timescale 1ns/1ps
`default_nettype none
module cphl_host_asserts
  import cphl_pkg::*;
(
  input wire logic         sys_clk_in,
  input wire logic         rstn_in,
  input wire logic         cmd_valid_in,
  input wire logic [5:0]   cmd_code_in,
  input wire logic         cmd_ready_out,
  input wire logic         cmd_done_out,
  input wire logic         cmd_nak_out,
  input wire logic         cmd_fail_out,
  input wire logic         tx_valid_out,
  input wire logic [7:0]   tx_data_out,
  input wire logic         tx_ready_in,
  input wire logic         pkt_valid_out,
  input wire cphl_rx_pkt_t pkt_out,
  input wire logic         key_valid_out,
  input wire logic         fan_valid_out,
  input wire cphl_fan_t    fan_state_out,
  input wire logic         temp_valid_out,
  input wire logic         crc_err_out
);
  // One clock domain, checks rest during reset
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  cphl_fan_t fan_exp;
  logic      ack_any;
  // Fan class expected from the tach count, and any command ending
  assign fan_exp = (pkt_out.pay1 < FAN_STOP_LIMIT) ? FAN_STOPPED : (pkt_out.pay1 < FAN_SLOW_LIMIT) ? FAN_SLOW :
                   (pkt_out.pay1 == FAN_INVALID) ? FAN_BAD : FAN_RUN;
  assign ack_any = cmd_done_out | cmd_nak_out | cmd_fail_out;

  chk_take_busy: assert property (cmd_valid_in && cmd_ready_out |=> !cmd_ready_out)
    else $error("ready stayed high after a take");
  chk_type_first: assert property (cmd_valid_in && cmd_ready_out |->
    ##2 tx_valid_out && tx_data_out == {CLASS_CMD, $past(cmd_code_in, 2)})
    else $error("first byte is not the command type");
  chk_tx_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
    else $error("byte dropped before taken");
  chk_ack_release: assert property (ack_any |=> cmd_ready_out && !ack_any)
    else $error("command end not one pulse");
  chk_key_type: assert property (key_valid_out |-> pkt_valid_out && pkt_out.ptype == TYPE_KEY_REPORT &&
    pkt_out.pay0 inside {[8'h01:KEY_LAST_CODE]})
    else $error("key pulse on wrong packet");
  chk_fan_state: assert property (fan_valid_out |->
    pkt_valid_out && pkt_out.ptype == TYPE_FAN_REPORT && fan_state_out == fan_exp)
    else $error("fan class wrong");
  chk_temp_type: assert property (temp_valid_out |-> pkt_valid_out && pkt_out.ptype == TYPE_TEMP_REPORT)
    else $error("temperature pulse on wrong packet");
  chk_len_limit: assert property (pkt_valid_out |-> pkt_out.len <= MAX_PAYLOAD && !crc_err_out)
    else $error("oversize or failed packet delivered");

  // Main scenarios reached
  cover property (cmd_done_out);
  cover property (key_valid_out);
  cover property (cmd_fail_out);
  cover property (cmd_nak_out);
  cover property (crc_err_out);
endmodule : cphl_host_asserts

bind cphl_host cphl_host_asserts cphl_host_asserts_i (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
  .cmd_valid_in(cmd_valid_in), .cmd_code_in(cmd_code_in), .cmd_ready_out(cmd_ready_out),
  .cmd_done_out(cmd_done_out), .cmd_nak_out(cmd_nak_out), .cmd_fail_out(cmd_fail_out),
  .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in),
  .pkt_valid_out(pkt_valid_out), .pkt_out(pkt_out), .key_valid_out(key_valid_out),
  .fan_valid_out(fan_valid_out), .fan_state_out(fan_state_out), .temp_valid_out(temp_valid_out),
  .crc_err_out(crc_err_out));
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the host link controller and its FIFO.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cphl_pkg::*;
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, (a), (e)); end end
  typedef struct {logic c; logic [7:0] t, n, b; logic [1:0] m; logic s; logic [4:0] f; logic [7:0] v;} cphl_row_t;
  logic clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, dev_slow = 1'b0;
  logic [5:0] cmd_code = 6'h00;
  logic [7:0] cmd_len = 8'h00, txd, rxd, kc;
  logic [175:0] cmd_pay = '0;
  logic [1:0] dev_mode = 2'h0;
  logic cr, done, nak, fail, txv, txr, rxv, rxr, pv, kv, fv, tv, ce;
  cphl_rx_pkt_t pkt;
  cphl_fan_t fs;
  int n_errors = 0;
  int n_tests = 0;
  int i, k;
  // Reports: pkt,key,fan,temp,err; commands: done,nak,fail and sends
  cphl_row_t rows [14] = '{
    '{0, 8'h80, 1, 8'h01, 0, 0, 5'b11000, 8'h01}, '{0, 8'h80, 1, 8'h0C, 0, 0, 5'b11000, 8'h0C},
    '{0, 8'h81, 3, 8'h01, 0, 0, 5'b10100, 8'h02}, '{0, 8'h81, 3, 8'h02, 0, 0, 5'b10100, 8'h01},
    '{0, 8'h81, 3, 8'hFE, 0, 0, 5'b10100, 8'h03}, '{0, 8'h81, 3, 8'h0F, 0, 0, 5'b10100, 8'h00},
    '{0, 8'h82, 4, 8'h00, 0, 0, 5'b10010, 8'h00}, '{0, 8'h80, 1, 8'h02, 1, 0, 5'b00001, 8'h00},
    '{0, 8'h80, 23, 8'h00, 0, 0, 5'b00001, 8'h00}, '{1, 8'h05, 0, 8'h00, 0, 0, 5'b10000, 8'h01},
    '{1, 8'h3F, 22, 8'hA0, 0, 1, 5'b10000, 8'h01}, '{1, 8'h09, 9, 8'h10, 1, 0, 5'b01000, 8'h01},
    '{1, 8'h02, 16, 8'h40, 3, 0, 5'b10000, 8'h01}, '{1, 8'h00, 1, 8'h33, 2, 0, 5'b00100, 8'h04}};

  cphl_host #(.ACK_CYCLES(200)) cphl_host_i (.sys_clk_in(clk), .rstn_in(rstn), .cmd_valid_in(cmd_valid),
    .cmd_code_in(cmd_code), .cmd_len_in(cmd_len), .cmd_payload_in(cmd_pay), .cmd_ready_out(cr),
    .cmd_done_out(done), .cmd_nak_out(nak), .cmd_fail_out(fail), .tx_valid_out(txv), .tx_data_out(txd),
    .tx_ready_in(txr), .rx_valid_in(rxv), .rx_data_in(rxd), .rx_ready_out(rxr), .pkt_valid_out(pv),
    .pkt_out(pkt), .key_valid_out(kv), .key_code_out(kc), .fan_valid_out(fv), .fan_state_out(fs),
    .temp_valid_out(tv), .crc_err_out(ce));
  cphl_dev_model cphl_dev_model_i (.sys_clk_in(clk), .rstn_in(rstn), .tx_valid_in(txv), .tx_data_in(txd),
    .tx_ready_out(txr), .rx_valid_out(rxv), .rx_data_out(rxd), .rx_ready_in(rxr), .mode_in(dev_mode),
    .slow_in(dev_slow));

  // 250 MHz clock
  always #2 clk = ~clk;

  // Payload bytes counting up from a base
  function automatic logic [175:0] pay(input logic [7:0] b);
    for (int j = 0; j < 22; j++) pay[8*j +: 8] = b + j[7:0];
  endfunction : pay

  // Wait for a command end or a packet outcome
  task wait_ev(input logic cmd);
    for (int j = 0; j < 3000; j++) begin
      @(posedge clk);
      #1;
      if (cmd ? (done | nak | fail) : (pv | ce)) break;
    end
  endtask : wait_ev

  // Print counts and verdict, then stop
  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    #1;
    `CHK({cr, txv, rxr, pv, done}, 5'b10100);
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    $display("reset test done");
    for (i = 0; i < 14; i++) begin
      if (rows[i].c) begin
        k = cphl_dev_model_i.pkts;
        @(posedge clk);
        dev_mode  <= rows[i].m;
        dev_slow  <= rows[i].s;
        cmd_valid <= 1'b1;
        cmd_code  <= rows[i].t[5:0];
        cmd_len   <= rows[i].n;
        cmd_pay   <= pay(rows[i].b);
        @(posedge clk);
        cmd_valid <= 1'b0;
        wait_ev(1'b1);
        `CHK({done, nak, fail}, rows[i].f[4:2]);
        `CHK(cphl_dev_model_i.pkts - k, int'(rows[i].v));
        `CHK(cphl_dev_model_i.bad_cnt, 0);
        `CHK({cphl_dev_model_i.rb[0], cphl_dev_model_i.rb[1]}, {CLASS_CMD, rows[i].t[5:0], rows[i].n});
        if (rows[i].n != 0) `CHK(cphl_dev_model_i.rb[rows[i].n + 1], rows[i].b + rows[i].n - 8'h01);
      end else begin
        cphl_dev_model_i.send_pkt(rows[i].t, rows[i].n, pay(rows[i].b), rows[i].m[0]);
        wait_ev(1'b0);
        `CHK({pv, kv, fv, tv, ce}, rows[i].f);
        if (rows[i].f[3]) `CHK(kc, rows[i].v);
        if (rows[i].f[2]) `CHK(fs, rows[i].v[1:0]);
        if (rows[i].f[4]) `CHK({pkt.ptype, pkt.len}, {rows[i].t, rows[i].n});
      end
      $display("row %0d done", i);
    end
    // Receive buffer through the top: bytes pass in order, ready still high once the packet is parsed
    cphl_dev_model_i.send_pkt(TYPE_KEY_REPORT, 8'h01, pay(8'h06), 1'b0);
    wait_ev(1'b0);
    `CHK({rxr, kv, kc}, {1'b1, 1'b1, 8'h06});
    $display("buffer test done");
    // Reset in the middle of a command send, then a command at the first edge after release
    @(posedge clk);
    dev_mode  <= 2'h2;
    cmd_valid <= 1'b1;
    cmd_code  <= 6'h11;
    cmd_len   <= 8'h00;
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK({cr, txv}, 2'b01);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK({cr, txv, rxr, pv, done}, 5'b10100);
    @(posedge clk);
    rstn      <= 1'b1;
    dev_mode  <= 2'h0;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    wait_ev(1'b1);
    `CHK({done, nak, fail}, 3'b100);
    `CHK({cphl_dev_model_i.rb[0], cphl_dev_model_i.rb[1]}, {CLASS_CMD, 6'h11, 8'h00});
    $display("mid reset test done");
    complete_run;
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("watchdog expired");
    complete_run;
  end
endmodule : tb
`default_nettype wire
